// file: pft_consts.svh
`ifndef PFT_CONSTS_SVH
`define PFT_CONSTS_SVH
// Bus commands carried on the command/byte-enable lines in the address phase.
`define PFT_CMD_INTA   4'h0
`define PFT_CMD_SPEC   4'h1
`define PFT_CMD_IO_RD  4'h2
`define PFT_CMD_IO_WR  4'h3
`define PFT_CMD_MEM_RD 4'h6
`define PFT_CMD_MEM_WR 4'h7
`define PFT_CMD_CFG_RD 4'hA
`define PFT_CMD_CFG_WR 4'hB
`define PFT_CMD_MEM_RM 4'hC
`define PFT_CMD_DAC    4'hD
`define PFT_CMD_MEM_RL 4'hE
`define PFT_CMD_MEM_WI 4'hF
// Configuration dword indices (byte offset divided by four).
`define PFT_IDX_ID     6'h00
`define PFT_IDX_CMD    6'h01
`define PFT_IDX_CLASS  6'h02
`define PFT_IDX_BAR    6'h04
`define PFT_IDX_MEMB   6'h07
`define PFT_IDX_MEML   6'h08
`define PFT_IDX_IOB    6'h0B
`define PFT_IDX_IOL    6'h0C
`define PFT_IDX_INT    6'h0F
// Command register bit positions and reset value.
`define PFT_BIT_IO     0
`define PFT_BIT_MEM    1
`define PFT_BIT_MST    2
`define PFT_CMD_RESET  3'h0
`define PFT_NUM_FUNC   2
`define PFT_FIFO_DEPTH 4
`define PFT_FIFO_WIDTH 36
`define PFT_ZERO32     32'h0000_0000
`endif

// file: pft_pkg.sv
package pft_pkg;
    typedef enum logic [1:0] {S_IDLE, S_CLAIM, S_DATA, S_TURN} pft_state_t;
endpackage : pft_pkg

// file: pft_front_end.sv
`include "pft_consts.svh"

// Depth must be a power of two so that the pointers wrap by themselves.
module pft_fifo #(
    parameter int W = 36,
    parameter int D = 4
) (
    input  wire logic         i_clk,
    input  wire logic         i_reset_n,
    input  wire logic         i_flush,
    input  wire logic         i_valid,
    output logic              o_ready,
    input  wire logic [W-1:0] i_data,
    output logic              o_valid,
    input  wire logic         i_ready,
    output logic [W-1:0]      o_data,
    output logic [$clog2(D):0] o_cnt_d
);
    localparam int AW = $clog2(D);
    localparam logic [AW:0] FULL = (AW+1)'(D);
    logic [W-1:0]  mem_q [D];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;
    logic          push;
    logic          pop;

    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;
    assign o_data  = mem_q[rp_q];

    always_comb
    begin
        o_cnt_d = cnt_q;
        if (i_flush)
            o_cnt_d = '0;
        else if (push && !pop)
            o_cnt_d = cnt_q + 1'b1;
        else if (pop && !push)
            o_cnt_d = cnt_q - 1'b1;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n || i_flush)
        begin
            wp_q    <= '0;
            rp_q    <= '0;
            cnt_q   <= '0;
            o_valid <= 1'b0;
            o_ready <= 1'b1;
        end
        else
        begin
            if (push)
                wp_q <= wp_q + 1'b1;
            if (pop)
                rp_q <= rp_q + 1'b1;
            cnt_q   <= o_cnt_d;
            o_valid <= o_cnt_d != '0;
            o_ready <= o_cnt_d != FULL;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (push)
            mem_q[wp_q] <= i_data;
    end
endmodule : pft_fifo

// What this block does
// - Decode I/O read 0010, I/O write 0011, memory read 0110, write 0111.
// - Config read/write 1010/1011; 1100, 1110, 1111 are memory commands.
// - Never claim or issue 0000, 0001, 1101 or reserved 0100/0101/1000/1001.
// - A claimed cycle gets DEVSEL asserted with medium decode timing.
// - Claim follows the address decode plus windows and enable bits.
// - Command bit 0 gates I/O claims, bit 1 gates memory claims.
// - Bus mastering is requested only while command bit 2 is set.
// - Two functions with own headers: 0 for socket A, 1 for socket B.
// - Function 0 signals on INTA, function 1 on INTB.
// - Card traffic passes only through host-programmed memory and I/O windows.
// - Internal registers reachable by configuration and by a memory window.
// - Bursts are accepted toward the card side in both directions.
// - Burst data moves without waits until the FIFO is empty or full.
// - Type 0 config claimed only with IDSEL and function number 0 or 1.
// - Register number indexes dwords; byte enables pick bytes in data phase.
module pft_front_end #(
    parameter logic [31:0] ID_CODE    = 32'h0001_0001, // Arbitrary value.
    parameter logic [31:0] CLASS_CODE = 32'h0607_0000
) (
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    input  wire logic        i_frame_n,
    input  wire logic        i_irdy_n,
    input  wire logic        i_idsel,
    input  wire logic [31:0] i_ad,
    input  wire logic [3:0]  i_cbe_n,
    output logic      [31:0] o_ad,
    output logic             o_ad_oe,
    output logic             o_devsel_n,
    output logic             o_trdy_n,
    output logic             o_tgt_oe,
    output logic             o_inta_n,
    output logic             o_intb_n,
    input  wire logic [1:0]  i_card_irq,
    input  wire logic        i_mst_want,
    input  wire logic        i_mst_func,
    input  wire logic        i_mst_write,
    output logic             o_req_n,
    output logic      [3:0]  o_mst_cmd,
    output logic             o_card_busy,
    output logic             o_card_func,
    output logic             o_card_write,
    output logic      [31:0] o_card_addr,
    output logic             o_card_wvalid,
    output logic      [35:0] o_card_wdata,
    input  wire logic        i_card_wready,
    input  wire logic        i_card_rvalid,
    input  wire logic [31:0] i_card_rdata,
    output logic             o_card_rready
);
    localparam int NF = `PFT_NUM_FUNC;
    localparam logic [2:0] FULL = 3'(`PFT_FIFO_DEPTH);

    pft_pkg::pft_state_t st_q;
    logic [2:0]  cmd_q  [NF];
    logic [19:0] bar_q  [NF];
    logic [19:0] memb_q [NF];
    logic [19:0] meml_q [NF];
    logic [29:0] iob_q  [NF];
    logic [29:0] iol_q  [NF];
    logic [NF-1:0] mem_hit;
    logic [NF-1:0] bar_hit;
    logic [NF-1:0] io_hit;
    logic        frame_prev_q;
    logic        adr_ph;
    logic        is_io;
    logic        is_mem;
    logic        is_cfg;
    logic        hit_int;
    logic        hit_card;
    logic        hit_func;
    logic        int_q;
    logic        func_q;
    logic        wr_q;
    logic [5:0]  idx_q;
    logic [5:0]  idx_nx;
    logic        xfer;
    logic        last;
    logic [31:0] cfg_rd;
    logic        wf_ready;
    logic [2:0]  wf_cnt_d;
    logic        rf_valid;
    logic [31:0] rf_data;
    logic        rf_pop;
    logic        src_ok;
    logic        cfg_we;

    function automatic logic [31:0] pft_mrg(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0]  be_n);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
            if (!be_n[b])
                r[8*b +: 8] = nw[8*b +: 8];
        return r;
    endfunction : pft_mrg

    assign adr_ph = !i_frame_n && frame_prev_q && st_q == pft_pkg::S_IDLE;
    assign xfer   = st_q == pft_pkg::S_DATA && !o_trdy_n && !i_irdy_n;
    assign last   = xfer && i_frame_n;
    assign idx_nx = xfer ? idx_q + 6'h01 : idx_q;

    // Reserved, acknowledge, special and dual-address codes match nothing.
    always_comb
    begin
        is_io  = 1'b0;
        is_mem = 1'b0;
        is_cfg = 1'b0;
        unique case (i_cbe_n)
            `PFT_CMD_IO_RD, `PFT_CMD_IO_WR:
                is_io = 1'b1;
            `PFT_CMD_MEM_RD, `PFT_CMD_MEM_WR, `PFT_CMD_MEM_RM,
            `PFT_CMD_MEM_RL, `PFT_CMD_MEM_WI:
                is_mem = 1'b1;
            `PFT_CMD_CFG_RD, `PFT_CMD_CFG_WR:
                is_cfg = i_idsel && i_ad[1:0] == 2'b00
                         && i_ad[10:8] < 3'(NF);
            default:
                is_io = 1'b0;
        endcase
    end

    genvar f;
    generate
        for (f = 0; f < NF; f++)
        begin : g_func
            assign bar_hit[f] = cmd_q[f][`PFT_BIT_MEM] && is_mem
                                && i_ad[31:12] == bar_q[f];
            assign mem_hit[f] = cmd_q[f][`PFT_BIT_MEM] && is_mem
                                && i_ad[31:12] >= memb_q[f]
                                && i_ad[31:12] <= meml_q[f];
            assign io_hit[f]  = cmd_q[f][`PFT_BIT_IO] && is_io
                                && i_ad[31:2] >= iob_q[f]
                                && i_ad[31:2] <= iol_q[f];

            always_ff @(posedge i_clk)
            begin
                if (!i_reset_n)
                begin
                    cmd_q[f]  <= `PFT_CMD_RESET;
                    bar_q[f]  <= '0;
                    memb_q[f] <= '0;
                    meml_q[f] <= '0;
                    iob_q[f]  <= '0;
                    iol_q[f]  <= '0;
                end
                else if (cfg_we && func_q == 1'(f))
                begin
                    unique case (idx_q)
                        `PFT_IDX_CMD:
                            if (!i_cbe_n[0])
                                cmd_q[f] <= i_ad[2:0];
                        `PFT_IDX_BAR:
                            bar_q[f] <= 20'(pft_mrg({bar_q[f], 12'h000},
                                            i_ad, i_cbe_n) >> 12);
                        `PFT_IDX_MEMB:
                            memb_q[f] <= 20'(pft_mrg({memb_q[f], 12'h000},
                                             i_ad, i_cbe_n) >> 12);
                        `PFT_IDX_MEML:
                            meml_q[f] <= 20'(pft_mrg({meml_q[f], 12'h000},
                                             i_ad, i_cbe_n) >> 12);
                        `PFT_IDX_IOB:
                            iob_q[f] <= 30'(pft_mrg({iob_q[f], 2'b00},
                                            i_ad, i_cbe_n) >> 2);
                        `PFT_IDX_IOL:
                            iol_q[f] <= 30'(pft_mrg({iol_q[f], 2'b00},
                                            i_ad, i_cbe_n) >> 2);
                        default:
                            cmd_q[f] <= cmd_q[f];
                    endcase
                end
            end
        end
    endgenerate

    // Function 0 wins when both functions' windows overlap.
    assign hit_int  = is_cfg || |bar_hit;
    assign hit_card = !hit_int && (|mem_hit || |io_hit);
    assign hit_func = is_cfg ? i_ad[8]
                    : !(bar_hit[0] || mem_hit[0] || io_hit[0]);
    assign cfg_we   = xfer && int_q && wr_q;

    always_comb
    begin
        unique case (idx_nx)
            `PFT_IDX_ID:    cfg_rd = ID_CODE;
            `PFT_IDX_CMD:   cfg_rd = {29'h0000_0000, cmd_q[func_q]};
            `PFT_IDX_CLASS: cfg_rd = CLASS_CODE;
            `PFT_IDX_BAR:   cfg_rd = {bar_q[func_q], 12'h000};
            `PFT_IDX_MEMB:  cfg_rd = {memb_q[func_q], 12'h000};
            `PFT_IDX_MEML:  cfg_rd = {meml_q[func_q], 12'h000};
            `PFT_IDX_IOB:   cfg_rd = {iob_q[func_q], 2'b00};
            `PFT_IDX_IOL:   cfg_rd = {iol_q[func_q], 2'b00};
            `PFT_IDX_INT:   cfg_rd = {23'h00_0000, 1'b1, 7'h00, func_q};
            default:        cfg_rd = `PFT_ZERO32;
        endcase
    end

    // Read data sits in o_ad until taken, so the next word loads with no
    // wait state while the read FIFO holds one.
    assign src_ok = int_q || rf_valid;
    assign rf_pop = !wr_q && !int_q && st_q == pft_pkg::S_DATA
                    && (o_trdy_n || xfer) && rf_valid;

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            st_q         <= pft_pkg::S_IDLE;
            frame_prev_q <= 1'b1;
            o_devsel_n   <= 1'b1;
            o_trdy_n     <= 1'b1;
            o_tgt_oe     <= 1'b0;
            o_ad_oe      <= 1'b0;
            o_ad         <= `PFT_ZERO32;
            int_q        <= 1'b0;
            func_q       <= 1'b0;
            wr_q         <= 1'b0;
            idx_q        <= '0;
        end
        else
        begin
            frame_prev_q <= i_frame_n;
            unique case (st_q)
                pft_pkg::S_IDLE:
                    if (adr_ph && (hit_int || hit_card))
                    begin
                        st_q   <= pft_pkg::S_CLAIM;
                        int_q  <= hit_int;
                        func_q <= hit_func;
                        wr_q   <= i_cbe_n[0];
                        idx_q  <= i_ad[7:2];
                    end
                pft_pkg::S_CLAIM:
                begin
                    st_q       <= pft_pkg::S_DATA;
                    o_devsel_n <= 1'b0;
                    o_tgt_oe   <= 1'b1;
                    o_ad_oe    <= !wr_q;
                    o_trdy_n   <= !wr_q || int_q ? 1'b1 : !wf_ready;
                end
                pft_pkg::S_DATA:
                begin
                    if (xfer)
                        idx_q <= idx_nx;
                    if (last || (i_frame_n && i_irdy_n))
                    begin
                        st_q       <= pft_pkg::S_TURN;
                        o_devsel_n <= 1'b1;
                        o_trdy_n   <= 1'b1;
                        o_ad_oe    <= 1'b0;
                    end
                    else if (wr_q)
                        o_trdy_n <= int_q ? 1'b0 : wf_cnt_d == FULL;
                    else if ((o_trdy_n || xfer) && src_ok)
                    begin
                        o_ad     <= int_q ? cfg_rd : rf_data;
                        o_trdy_n <= 1'b0;
                    end
                    else if (xfer)
                        o_trdy_n <= 1'b1;
                end
                pft_pkg::S_TURN:
                begin
                    st_q     <= pft_pkg::S_IDLE;
                    o_tgt_oe <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            o_card_busy  <= 1'b0;
            o_card_func  <= 1'b0;
            o_card_write <= 1'b0;
            o_card_addr  <= `PFT_ZERO32;
        end
        else if (adr_ph && hit_card)
        begin
            o_card_busy  <= 1'b1;
            o_card_func  <= hit_func;
            o_card_write <= i_cbe_n[0];
            o_card_addr  <= i_ad;
        end
        else if (st_q == pft_pkg::S_TURN)
            o_card_busy <= 1'b0;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            o_req_n   <= 1'b1;
            o_mst_cmd <= `PFT_CMD_MEM_RD;
            o_inta_n  <= 1'b1;
            o_intb_n  <= 1'b1;
        end
        else
        begin
            o_req_n   <= !(i_mst_want
                           && cmd_q[i_mst_func][`PFT_BIT_MST]);
            o_mst_cmd <= i_mst_write ? `PFT_CMD_MEM_WR
                                     : `PFT_CMD_MEM_RD;
            o_inta_n  <= !i_card_irq[0];
            o_intb_n  <= !i_card_irq[1];
        end
    end

    // Prefetched words beyond the last taken one are dropped at turnaround.
    pft_fifo #(.W(`PFT_FIFO_WIDTH), .D(`PFT_FIFO_DEPTH)) u_wr_fifo (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_flush   (1'b0),
        .i_valid   (xfer && wr_q && !int_q),
        .o_ready   (wf_ready),
        .i_data    ({i_cbe_n, i_ad}),
        .o_valid   (o_card_wvalid),
        .i_ready   (i_card_wready),
        .o_data    (o_card_wdata),
        .o_cnt_d   (wf_cnt_d)
    );

    pft_fifo #(.W(32), .D(`PFT_FIFO_DEPTH)) u_rd_fifo (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_flush   (st_q == pft_pkg::S_TURN),
        .i_valid   (i_card_rvalid),
        .o_ready   (o_card_rready),
        .i_data    (i_card_rdata),
        .o_valid   (rf_valid),
        .i_ready   (rf_pop),
        .o_data    (rf_data),
        .o_cnt_d   ()
    );

    property p_devsel_medium;
        @(posedge i_clk) disable iff (!i_reset_n)
        adr_ph && (hit_int || hit_card) |-> ##1 o_devsel_n ##1 !o_devsel_n;
    endproperty
    a_devsel_medium: assert property (p_devsel_medium)
        else $error("claimed cycle did not get DEVSEL at the medium slot");

    property p_no_illegal;
        @(posedge i_clk) disable iff (!i_reset_n)
        adr_ph && (i_cbe_n inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9,
                                   4'hD}) |-> ##2 o_devsel_n;
    endproperty
    a_no_illegal: assert property (p_no_illegal)
        else $error("illegal command was claimed");

    property p_io_gate;
        @(posedge i_clk) disable iff (!i_reset_n)
        adr_ph && is_io && !cmd_q[0][`PFT_BIT_IO] && !cmd_q[1][`PFT_BIT_IO]
        |-> ##1 st_q == pft_pkg::S_IDLE ##1 o_devsel_n;
    endproperty
    a_io_gate: assert property (p_io_gate)
        else $error("I/O cycle claimed while I/O disabled");

    property p_mem_gate;
        @(posedge i_clk) disable iff (!i_reset_n)
        adr_ph && is_mem && !cmd_q[0][`PFT_BIT_MEM]
        && !cmd_q[1][`PFT_BIT_MEM] |-> ##2 o_devsel_n;
    endproperty
    a_mem_gate: assert property (p_mem_gate)
        else $error("memory cycle claimed while memory disabled");

    property p_cfg_func;
        @(posedge i_clk) disable iff (!i_reset_n)
        adr_ph && i_cbe_n inside {4'hA, 4'hB}
        && (!i_idsel || i_ad[10:8] >= 3'h2) |-> ##2 o_devsel_n;
    endproperty
    a_cfg_func: assert property (p_cfg_func)
        else $error("configuration cycle claimed without a valid function");

    property p_master_gate;
        @(posedge i_clk) disable iff (!i_reset_n)
        !cmd_q[i_mst_func][`PFT_BIT_MST] |=> o_req_n;
    endproperty
    a_master_gate: assert property (p_master_gate)
        else $error("bus request raised while mastering disabled");

    property p_reset_clear;
        @(posedge i_clk)
        !i_reset_n |=> cmd_q[0] == 3'h0 && cmd_q[1] == 3'h0 && o_req_n;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("enable bits not clear after reset");

    property p_wr_room;
        @(posedge i_clk) disable iff (!i_reset_n)
        xfer && wr_q && !int_q |-> wf_ready;
    endproperty
    a_wr_room: assert property (p_wr_room)
        else $error("write data taken with the FIFO full");

    property p_intb;
        @(posedge i_clk) disable iff (!i_reset_n)
        $rose(i_card_irq[1])
        |=> !o_intb_n && o_inta_n == !$past(i_card_irq[0]);
    endproperty
    a_intb: assert property (p_intb)
        else $error("function 1 interrupt not on INTB");
endmodule : pft_front_end

// file: pft_host_model.sv
module pft_host_model (
    input  wire logic        i_clk,
    input  wire logic        i_devsel_n,
    input  wire logic        i_trdy_n,
    input  wire logic [31:0] i_ad,
    output logic             o_frame_n,
    output logic             o_irdy_n,
    output logic             o_idsel,
    output logic [31:0]      o_ad,
    output logic [3:0]       o_cbe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] rd_q[$];
    int          dsel_at;
    int          stall_at;

    initial
    begin
        o_frame_n = 1'b1;
        o_irdy_n  = 1'b1;
        o_idsel   = 1'b0;
        o_ad      = 32'h0000_0000;
        o_cbe_n   = 4'hF;
    end

    // An unclaimed cycle ends after a bounded wait, so a silent target
    // never hangs the run.
    task automatic xfer(input logic [3:0]  cmd,
                        input logic [31:0] addr,
                        input logic        sel,
                        input int          n,
                        input logic [31:0] wd);
        int t;
        int e;
        rd_q = {};
        dsel_at = 0;
        stall_at = -1;
        e = 0;
        @(negedge i_clk);
        o_frame_n = 1'b0;
        o_ad = addr;
        o_cbe_n = cmd;
        o_idsel = sel;
        @(negedge i_clk);
        o_idsel = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            if (i > 0)
                @(negedge i_clk);
            o_frame_n = (i == n - 1);
            o_irdy_n = 1'b0;
            o_ad = cmd[0] ? wd + i : ~wd;
            o_cbe_n = 4'h0;
            t = 0;
            do
            begin
                @(posedge i_clk);
                e++;
                t++;
                if (dsel_at == 0 && i_devsel_n === 1'b0)
                    dsel_at = e;
            end
            while (i_trdy_n !== 1'b0 && t < 20);
            if (i_trdy_n !== 1'b0)
                break;
            if (i > 0 && t > 1 && stall_at < 0)
                stall_at = i;
            rd_q.push_back(i_ad);
        end
        @(negedge i_clk);
        o_frame_n = 1'b1;
        o_irdy_n = 1'b1;
        o_ad = ~o_ad;
        o_cbe_n = ~o_cbe_n;
        repeat (3) @(negedge i_clk);
    endtask : xfer
endmodule : pft_host_model

// file: testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] ID = 32'h1234_5678; // Arbitrary value.
    logic i_clk, i_reset_n, frame_n, irdy_n, idsel, ad_oe, devsel_n;
    logic trdy_n, tgt_oe, inta_n, intb_n, mst_want, mst_func, mst_write;
    logic req_n, card_busy, card_func, card_write, wvalid, wready;
    logic rvalid, rready, taken;
    logic [31:0] ad, dut_ad, card_addr, rdata;
    logic [3:0]  cbe_n, mst_cmd;
    logic [1:0]  card_irq;
    logic [35:0] wdata;
    logic [35:0] wq[$];
    int          fails, num_checks, cycles;

    pft_front_end #(.ID_CODE(ID)) pft_front_end_i (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_frame_n(frame_n),
        .i_irdy_n(irdy_n), .i_idsel(idsel), .i_ad(ad), .i_cbe_n(cbe_n),
        .o_ad(dut_ad), .o_ad_oe(ad_oe), .o_devsel_n(devsel_n),
        .o_trdy_n(trdy_n), .o_tgt_oe(tgt_oe), .o_inta_n(inta_n),
        .o_intb_n(intb_n), .i_card_irq(card_irq), .i_mst_want(mst_want),
        .i_mst_func(mst_func), .i_mst_write(mst_write), .o_req_n(req_n),
        .o_mst_cmd(mst_cmd), .o_card_busy(card_busy),
        .o_card_func(card_func), .o_card_write(card_write),
        .o_card_addr(card_addr), .o_card_wvalid(wvalid),
        .o_card_wdata(wdata), .i_card_wready(wready),
        .i_card_rvalid(rvalid), .i_card_rdata(rdata),
        .o_card_rready(rready));

    pft_host_model pft_host_model_i (
        .i_clk(i_clk), .i_devsel_n(devsel_n), .i_trdy_n(trdy_n),
        .i_ad(dut_ad), .o_frame_n(frame_n), .o_irdy_n(irdy_n),
        .o_idsel(idsel), .o_ad(ad), .o_cbe_n(cbe_n));

    initial
    begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    // The card side pops written words and advances read data per word.
    always @(posedge i_clk)
    begin
        cycles++;
        taken <= rvalid && rready;
        if (wvalid && wready)
            wq.push_back(wdata);
        if (cycles == 20000)
        begin
            fails++;
            finish_test();
        end
    end
    always @(negedge i_clk)
        if (taken)
            rdata <= rdata + 32'h0000_0001;

    task automatic check(input string what, input logic [35:0] seen,
                         input logic [35:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic cfg(input logic wr, input logic [2:0] fn,
                       input logic [5:0] idx, input logic [31:0] d);
        pft_host_model_i.xfer({3'b101, wr}, {21'h0, fn, idx, 2'b00}, 1'b1,
                              1, d);
    endtask : cfg

    task automatic t_reset();
        check("req", req_n, 1);
        cfg(0, 0, 1, 0);
        check("cmd", pft_host_model_i.rd_q[0][2:0], 0);
        check("devsel", pft_host_model_i.dsel_at, 2);
        pft_host_model_i.xfer(4'h6, 0, 0, 1, 0);
        check("mem off", pft_host_model_i.dsel_at, 0);
    endtask : t_reset

    task automatic t_config();
        cfg(1, 0, 1, 32'h0000_0003);
        cfg(0, 0, 1, 0);
        check("cmd", pft_host_model_i.rd_q[0][2:0], 3'h3);
        cfg(0, 1, 1, 0);
        check("fn1 cmd", pft_host_model_i.rd_q[0][2:0], 0);
        cfg(0, 0, 0, 0);
        check("id", pft_host_model_i.rd_q[0], ID);
        cfg(0, 2, 0, 0);
        check("fn2", pft_host_model_i.dsel_at, 0);
        pft_host_model_i.xfer(4'hA, 0, 0, 1, 0);
        check("no idsel", pft_host_model_i.dsel_at, 0);
    endtask : t_config

    task automatic t_commands();
        logic [3:0] bad[7] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hD};
        logic [3:0] rd[3] = '{4'h6, 4'hC, 4'hE};
        foreach (bad[i])
        begin
            pft_host_model_i.xfer(bad[i], 0, 1'b1, 1, 0);
            check("illegal", pft_host_model_i.dsel_at, 0);
        end
        foreach (rd[i])
        begin
            pft_host_model_i.xfer(rd[i], 0, 0, 1, 0);
            check("window", pft_host_model_i.rd_q[0], ID);
        end
        pft_host_model_i.xfer(4'hF, 0, 0, 1, 0);
        check("mwi", pft_host_model_i.dsel_at, 2);
    endtask : t_commands

    task automatic t_master();
        mst_want = 1'b1;
        mst_write = 1'b1;
        repeat (3) @(negedge i_clk);
        check("req off", req_n, 1);
        cfg(1, 0, 1, 32'h0000_0007);
        check("req on", req_n, 0);
        check("mst cmd", mst_cmd, 4'h7);
        mst_write = 1'b0;
        repeat (2) @(negedge i_clk);
        check("mst cmd", mst_cmd, 4'h6);
        mst_want = 1'b0;
        card_irq = 2'b10;
        repeat (2) @(negedge i_clk);
        check("int", {inta_n, intb_n}, 2'b10);
        card_irq = 2'b01;
        repeat (2) @(negedge i_clk);
        check("int", {inta_n, intb_n}, 2'b01);
    endtask : t_master

    task automatic t_card();
        cfg(1, 0, 7, 32'h1000_0000);
        cfg(1, 0, 8, 32'h1000_0000);
        fork
            pft_host_model_i.xfer(4'h7, 32'h1000_0100, 0, 6, 32'hA000_0000);
            begin
                repeat (14) @(negedge i_clk);
                check("busy", card_busy, 1);
                wready = 1'b1;
            end
        join
        check("stall", pft_host_model_i.stall_at, 4);
        check("addr", card_addr, 32'h1000_0100);
        check("dir", card_write, 1);
        check("func", card_func, 0);
        check("idle", card_busy, 0);
        check("words", wq.size(), 6);
        foreach (wq[i])
            check("wdata", wq[i], 36'hA000_0000 + i);
        rvalid = 1'b1;
        pft_host_model_i.xfer(4'h6, 32'h1000_0200, 0, 4, 0);
        check("rd stall", pft_host_model_i.stall_at, -1);
        check("rd words", pft_host_model_i.rd_q.size(), 4);
        foreach (pft_host_model_i.rd_q[i])
            check("rd", pft_host_model_i.rd_q[i], 32'hB000_0000 + i);
        check("rd dir", card_write, 0);
        cfg(1, 0, 11, 32'h0000_1000);
        cfg(1, 0, 12, 32'h0000_1000);
        pft_host_model_i.xfer(4'h2, 32'h0000_1000, 0, 1, 0);
        check("io claim", pft_host_model_i.dsel_at, 2);
        check("io addr", card_addr, 32'h0000_1000);
        check("io rd dir", card_write, 0);
        pft_host_model_i.xfer(4'h3, 32'h0000_1000, 0, 1, 32'hC000_0000);
        check("io wr dir", card_write, 1);
        check("io words", wq.size(), 7);
        check("io wdata", wq[6], 36'h0_C000_0000);
        check("released", {tgt_oe, ad_oe, devsel_n, trdy_n}, 4'h3);
        cfg(1, 0, 1, 32'h0000_0000);
        pft_host_model_i.xfer(4'h6, 32'h1000_0200, 0, 1, 0);
        check("mem off", pft_host_model_i.dsel_at, 0);
    endtask : t_card

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    initial
    begin
        i_reset_n = 1'b0;
        {mst_want, mst_func, mst_write, wready, rvalid} = '0;
        card_irq = 2'b00;
        rdata = 32'hB000_0000;
        repeat (6) @(negedge i_clk);
        i_reset_n = 1'b1;
        repeat (2) @(negedge i_clk);
        t_reset();
        t_config();
        t_commands();
        t_master();
        t_card();
        finish_test();
    end
endmodule : testbench
